// ==== ufc_pkg.sv ====
// constants for the uart fifo and flow-control configuration block
`default_nettype none
package ufc_pkg;
   // register offsets on the internal register port
   localparam logic [2:0] OFS_DATA      = 3'h0;
   localparam logic [2:0] OFS_INT_EN    = 3'h1;
   localparam logic [2:0] OFS_FIFO_CTL  = 3'h2;
   localparam logic [2:0] OFS_ENH_FEAT  = 3'h2;
   localparam logic [2:0] OFS_LINE_CTL  = 3'h3;
   localparam logic [2:0] OFS_MODEM_CTL = 3'h4;
   localparam logic [2:0] OFS_RESUME1   = 3'h4;
   localparam logic [2:0] OFS_RESUME2   = 3'h5;
   localparam logic [2:0] OFS_PAUSE1    = 3'h6;
   localparam logic [2:0] OFS_PAUSE2    = 3'h7;

   // line_control value that opens the enhanced bank
   localparam logic [7:0] LINE_CTL_ENH_KEY = 8'hbf;
   localparam int         LINE_CTL_DLAB    = 7;

   // reset values
   localparam logic [7:0] FIFO_CTL_RST  = 8'h00;
   localparam logic [7:0] ENH_FEAT_RST  = 8'h00;
   localparam logic [7:0] LINE_CTL_RST  = 8'h00;
   localparam logic [7:0] INT_EN_RST    = 8'h00;
   localparam logic [7:0] MODEM_CTL_RST = 8'h00;
   localparam logic [7:0] FLOW_CHAR_RST = 8'h00;

   // fifo_control fields
   localparam int FC_EN = 0;
   localparam int FC_RX_RST = 1;
   localparam int FC_TX_RST = 2;
   localparam int FC_TX_TRIG_LO = 4;
   localparam int FC_RX_TRIG_LO = 6;

   // enhanced_feature_control fields
   localparam int EF_AUTO_CTS = 7;
   localparam int EF_AUTO_RTS = 6;
   localparam int EF_SPECIAL  = 5;
   localparam int EF_ENHANCED = 4;

   // other bits used here
   localparam int IE_RX_READY = 0;
   localparam int IE_TX_READY = 1;
   localparam int IE_SLEEP    = 4;
   localparam int IE_SW_FLOW  = 5;
   localparam int MC_RTS      = 1;

   // fifo sizing and levels
   localparam int         LVL_W       = 7;
   localparam logic [6:0] DEPTH_FIFO  = 7'h40;
   localparam logic [6:0] DEPTH_PLAIN = 7'h01;
   localparam logic [6:0] TRIG_PLAIN  = 7'h01;
   localparam logic [3:0][6:0] RX_TRIG_TBL = {7'h3c, 7'h38, 7'h10, 7'h08};
   localparam logic [3:0][6:0] TX_TRIG_TBL = {7'h38, 7'h20, 7'h10, 7'h08};
   localparam logic [6:0] RX_HALT_LVL   = 7'h3c;
   localparam logic [6:0] RX_RESUME_LVL = 7'h20;

   // software flow-control select codes, two bits each
   localparam logic [1:0] SW_NONE  = 2'h0;
   localparam logic [1:0] SW_PAIR2 = 2'h1;
   localparam logic [1:0] SW_PAIR1 = 2'h2;
   localparam logic [1:0] SW_BOTH  = 2'h3;

   // interrupt_identification source codes, bits [5:1]
   localparam logic [4:0] ID_RX_DATA = 5'h02;
   localparam logic [4:0] ID_TX_RDY  = 5'h01;
   localparam logic [4:0] ID_SW_FLOW = 5'h08;
   localparam logic [4:0] ID_NONE    = 5'h00;
endpackage
`default_nettype wire

// ==== ufc_fifo.sv ====
// character fifo with run-time capacity and synchronous flush
`timescale 1ns/100ps
`default_nettype none
module ufc_fifo (
   input  wire logic       clk_i,
   input  wire logic       nrst_i,
   input  wire logic       flush_i,
   input  wire logic [6:0] cap_i,
   input  wire logic       push_valid_i,
   output logic            push_ready_o,
   input  wire logic [7:0] wr_data_i,
   output logic            pop_valid_o,
   input  wire logic       pop_ready_i,
   output logic [7:0]      rd_data_o,
   output logic [6:0]      level_o
);
   logic [7:0] mem_r [0:63];
   logic [5:0] wr_ptr_r;
   logic [5:0] rd_ptr_r;
   logic [6:0] count_r;
   wire        do_push;
   wire        do_pop;

   assign push_ready_o = (count_r < cap_i);
   assign pop_valid_o  = (count_r != 7'h00);
   assign rd_data_o    = mem_r[rd_ptr_r];
   assign level_o      = count_r;
   assign do_push      = push_valid_i & push_ready_o & ~flush_i;
   assign do_pop       = pop_ready_i & pop_valid_o & ~flush_i;

   // flush only touches pointers and count; stored words are simply abandoned
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i || flush_i)
      begin
         wr_ptr_r <= 6'h00;
         rd_ptr_r <= 6'h00;
         count_r  <= 7'h00;
      end
      else
      begin
         if (do_push)
            wr_ptr_r <= wr_ptr_r + 6'h01;
         if (do_pop)
            rd_ptr_r <= rd_ptr_r + 6'h01;
         if (do_push && !do_pop)
            count_r <= count_r + 7'h01;
         else if (do_pop && !do_push)
            count_r <= count_r - 7'h01;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (do_push)
         mem_r[wr_ptr_r] <= wr_data_i;
   end
endmodule
`default_nettype wire

// ==== ufc_top.sv ====
// uart fifo configuration, hardware and software flow control
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// R1: rx trigger code picks 8/16/56/60
// R2: tx trigger code picks 8/16/32/56 spaces
// R3: tx fifo reset empties, self-clears
// R4: rx fifo reset empties, self-clears
// R5: fifo off: one character, trigger one
// R6: fifo on: 64 characters each way
// R7: tx trigger writable only with enhanced
// R8: fifo_control at 02h, dlab low, reset 00
// R9: bit 7 enables automatic cts
// R10: bit 6 enables automatic rts
// R11: special char stored, flags identification
// R12: compared pause char: swallowed, both flags
// R13: enhanced bit gates upper bits, sleep
// R14: upper select bits pick transmit pair
// R15: lower select bits pick receive compare
// R16: 1011/0111: receive either character
// R17: 1111: send both, receive both in sequence
// R18: 0011: no transmit flow control
// R19: tx ready on spaces above trigger
// R20: rx ready while level at trigger
// R21: cts pauses between chars, rts near full
module ufc_top (
   input  wire logic       clk_i,
   input  wire logic       nrst_i,
   input  wire logic [2:0] reg_addr_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic [7:0]      reg_rdata_o,
   input  wire logic [7:0] rx_char_i,
   input  wire logic       rx_valid_i,
   output logic [7:0]      tx_char_o,
   output logic            tx_valid_o,
   input  wire logic       tx_ready_i,
   input  wire logic       cts_n_i,
   output logic            rts_n_o,
   output logic            rx_ready_int_o,
   output logic            tx_ready_int_o,
   output logic            sleep_en_o
);
   // ---------------- registers ----------------
   logic [7:0] line_control_r;
   logic [7:0] interrupt_enable_r;
   logic [7:0] modem_control_r;
   logic [7:0] fifo_control_r;
   logic [7:0] enhanced_feature_control_r;
   logic [7:0] resume_char_first_r;
   logic [7:0] resume_char_second_r;
   logic [7:0] pause_char_first_r;
   logic [7:0] pause_char_second_r;

   // ---------------- address decode ----------------
   wire bank_norm = ~line_control_r[ufc_pkg::LINE_CTL_DLAB];
   wire bank_enh  = (line_control_r == ufc_pkg::LINE_CTL_ENH_KEY);
   wire enh_on    = enhanced_feature_control_r[ufc_pkg::EF_ENHANCED];

   wire wr_data  = reg_wr_i & bank_norm & (reg_addr_i == ufc_pkg::OFS_DATA);
   wire wr_ie    = reg_wr_i & bank_norm
                   & (reg_addr_i == ufc_pkg::OFS_INT_EN);
   wire wr_fc    = reg_wr_i & bank_norm
                   & (reg_addr_i == ufc_pkg::OFS_FIFO_CTL); // see R8
   wire wr_ef    = reg_wr_i & bank_enh
                   & (reg_addr_i == ufc_pkg::OFS_ENH_FEAT);
   wire wr_lc    = reg_wr_i & (reg_addr_i == ufc_pkg::OFS_LINE_CTL);
   wire wr_mc    = reg_wr_i & bank_norm
                   & (reg_addr_i == ufc_pkg::OFS_MODEM_CTL);
   wire wr_on1   = reg_wr_i & bank_enh
                   & (reg_addr_i == ufc_pkg::OFS_RESUME1);
   wire wr_on2   = reg_wr_i & bank_enh
                   & (reg_addr_i == ufc_pkg::OFS_RESUME2);
   wire wr_off1  = reg_wr_i & bank_enh
                   & (reg_addr_i == ufc_pkg::OFS_PAUSE1);
   wire wr_off2  = reg_wr_i & bank_enh
                   & (reg_addr_i == ufc_pkg::OFS_PAUSE2);
   wire rd_data  = reg_rd_i & bank_norm & (reg_addr_i == ufc_pkg::OFS_DATA);
   wire rd_ident = reg_rd_i & bank_norm
                   & (reg_addr_i == ufc_pkg::OFS_FIFO_CTL);

   // ---------------- fifo control write ----------------
   wire       fifo_en   = fifo_control_r[ufc_pkg::FC_EN];
   wire       new_en    = reg_wdata_i[ufc_pkg::FC_EN];
   wire [1:0] rx_sel    = fifo_control_r[ufc_pkg::FC_RX_TRIG_LO +: 2];
   wire [1:0] tx_sel    = fifo_control_r[ufc_pkg::FC_TX_TRIG_LO +: 2];
   wire       flush_tx  = fifo_control_r[ufc_pkg::FC_TX_RST];
   wire       flush_rx  = fifo_control_r[ufc_pkg::FC_RX_RST];
   wire       en_change = wr_fc & (new_en != fifo_en);
   logic [7:0] fifo_control_nxt;

   always_comb
   begin
      fifo_control_nxt = fifo_control_r;
      // reset bits drop after the one flush cycle
      fifo_control_nxt[ufc_pkg::FC_TX_RST] = 1'b0; // see R3
      fifo_control_nxt[ufc_pkg::FC_RX_RST] = 1'b0; // see R4
      if (wr_fc)
      begin
         fifo_control_nxt[ufc_pkg::FC_EN] = new_en;
         if (new_en)
         begin
            fifo_control_nxt[ufc_pkg::FC_RX_TRIG_LO +: 2] =
               reg_wdata_i[ufc_pkg::FC_RX_TRIG_LO +: 2];
            if (enh_on)
               fifo_control_nxt[ufc_pkg::FC_TX_TRIG_LO +: 2] =
                  reg_wdata_i[ufc_pkg::FC_TX_TRIG_LO +: 2]; // see R7
            fifo_control_nxt[ufc_pkg::FC_TX_RST] =
               reg_wdata_i[ufc_pkg::FC_TX_RST]; // see R3
            fifo_control_nxt[ufc_pkg::FC_RX_RST] =
               reg_wdata_i[ufc_pkg::FC_RX_RST]; // see R4
         end
         // toggling the mode empties both sides so depth limits stay honest
         if (en_change)
         begin
            fifo_control_nxt[ufc_pkg::FC_TX_RST] = 1'b1;
            fifo_control_nxt[ufc_pkg::FC_RX_RST] = 1'b1;
         end
      end
   end

   // upper enable and modem bits only move with the enhanced bit
   wire [7:0] ie_nxt = enh_on ? reg_wdata_i // see R13
                       : {interrupt_enable_r[7:4], reg_wdata_i[3:0]};
   wire [7:0] mc_nxt = enh_on ? reg_wdata_i
                       : {modem_control_r[7:5], reg_wdata_i[4:0]}; // see R13

   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         line_control_r             <= ufc_pkg::LINE_CTL_RST;
         interrupt_enable_r         <= ufc_pkg::INT_EN_RST;
         modem_control_r            <= ufc_pkg::MODEM_CTL_RST;
         fifo_control_r             <= ufc_pkg::FIFO_CTL_RST; // see R8
         enhanced_feature_control_r <= ufc_pkg::ENH_FEAT_RST;
         resume_char_first_r        <= ufc_pkg::FLOW_CHAR_RST;
         resume_char_second_r       <= ufc_pkg::FLOW_CHAR_RST;
         pause_char_first_r         <= ufc_pkg::FLOW_CHAR_RST;
         pause_char_second_r        <= ufc_pkg::FLOW_CHAR_RST;
      end
      else
      begin
         fifo_control_r <= fifo_control_nxt;
         if (wr_lc)
            line_control_r <= reg_wdata_i;
         if (wr_ie)
            interrupt_enable_r <= ie_nxt;
         if (wr_mc)
            modem_control_r <= mc_nxt;
         if (wr_ef)
            enhanced_feature_control_r <= reg_wdata_i;
         if (wr_on1)
            resume_char_first_r <= reg_wdata_i;
         if (wr_on2)
            resume_char_second_r <= reg_wdata_i;
         if (wr_off1)
            pause_char_first_r <= reg_wdata_i;
         if (wr_off2)
            pause_char_second_r <= reg_wdata_i;
      end
   end

   // ---------------- fifos ----------------
   wire [6:0] cap = fifo_en ? ufc_pkg::DEPTH_FIFO
                    : ufc_pkg::DEPTH_PLAIN; // see R5 R6
   wire [6:0] rx_trig = fifo_en ? ufc_pkg::RX_TRIG_TBL[rx_sel]
                        : ufc_pkg::TRIG_PLAIN; // see R1 R5
   wire [6:0] tx_trig = fifo_en ? ufc_pkg::TX_TRIG_TBL[tx_sel]
                        : ufc_pkg::TRIG_PLAIN; // see R2 R5

   wire [6:0] tx_level;
   wire [6:0] rx_level;
   wire [7:0] tx_head;
   wire [7:0] rx_head;
   wire       tx_avail;
   wire       rx_avail;
   wire       tx_pop;
   wire       rx_push;

   // a full transmit fifo drops the host write; host must watch tx ready
   ufc_fifo u_tx_fifo (
      .clk_i        (clk_i),
      .nrst_i       (nrst_i),
      .flush_i      (flush_tx), // see R3
      .cap_i        (cap),
      .push_valid_i (wr_data),
      .push_ready_o (),
      .wr_data_i    (reg_wdata_i),
      .pop_valid_o  (tx_avail),
      .pop_ready_i  (tx_pop),
      .rd_data_o    (tx_head),
      .level_o      (tx_level)
   );

   // the receive shift register is outside; an overrun char is lost
   ufc_fifo u_rx_fifo (
      .clk_i        (clk_i),
      .nrst_i       (nrst_i),
      .flush_i      (flush_rx), // see R4
      .cap_i        (cap),
      .push_valid_i (rx_push),
      .push_ready_o (),
      .wr_data_i    (rx_char_i),
      .pop_valid_o  (rx_avail),
      .pop_ready_i  (rd_data),
      .rd_data_o    (rx_head),
      .level_o      (rx_level)
   );

   // ---------------- receive compare ----------------
   wire [1:0] sw_tx = enhanced_feature_control_r[3:2];
   wire [1:0] sw_rx = enhanced_feature_control_r[1:0];
   wire cmp_any = (sw_rx == ufc_pkg::SW_BOTH) & (sw_tx != ufc_pkg::SW_BOTH);
   wire cmp_seq = (sw_rx == ufc_pkg::SW_BOTH)
                  & (sw_tx == ufc_pkg::SW_BOTH); // see R17
   wire cmp1 = (sw_rx == ufc_pkg::SW_PAIR1) | cmp_any; // see R15 R16
   wire cmp2 = (sw_rx == ufc_pkg::SW_PAIR2) | cmp_any; // see R15 R16

   wire is_on1  = (rx_char_i == resume_char_first_r);
   wire is_on2  = (rx_char_i == resume_char_second_r);
   wire is_off1 = (rx_char_i == pause_char_first_r);
   wire is_off2 = (rx_char_i == pause_char_second_r);

   logic seq_on_r;
   logic seq_off_r;
   logic remote_pause_r;
   logic sw_flag_r;
   logic special_r;

   wire seq_on_hit  = cmp_seq & seq_on_r & is_on2;
   wire seq_off_hit = cmp_seq & seq_off_r & is_off2;
   wire seq_first   = cmp_seq & (is_on1 | is_off1);
   wire off_hit = rx_valid_i & ((cmp1 & is_off1) | (cmp2 & is_off2)
                                | seq_off_hit);
   wire on_hit  = rx_valid_i & ((cmp1 & is_on1) | (cmp2 & is_on2)
                                | seq_on_hit);
   // in sequence mode the first half is swallowed even if the second never follows
   wire flow_char = off_hit | on_hit | (rx_valid_i & seq_first);
   wire spec_hit  = rx_valid_i
                    & enhanced_feature_control_r[ufc_pkg::EF_SPECIAL]
                    & is_off2; // see R11
   assign rx_push = rx_valid_i & ~flow_char; // see R11 R12

   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         seq_on_r       <= 1'b0;
         seq_off_r      <= 1'b0;
         remote_pause_r <= 1'b0;
         sw_flag_r      <= 1'b0;
         special_r      <= 1'b0;
      end
      else
      begin
         if (rx_valid_i)
         begin
            seq_on_r  <= cmp_seq & is_on1;
            seq_off_r <= cmp_seq & is_off1;
         end
         if (off_hit)
            remote_pause_r <= 1'b1;
         else if (on_hit)
            remote_pause_r <= 1'b0;
         // a new event in the clearing read cycle survives
         if (off_hit)
            sw_flag_r <= 1'b1; // see R12
         else if (rd_ident)
            sw_flag_r <= 1'b0;
         if (spec_hit)
            special_r <= 1'b1; // see R11 R12
         else if (rd_ident)
            special_r <= 1'b0;
      end
   end

   // ---------------- receive halt (rts and pause chars) ----------------
   logic rx_halt_r;
   wire  rx_halt_nxt = (rx_level >= ufc_pkg::RX_HALT_LVL) ? 1'b1
                       : (rx_level <= ufc_pkg::RX_RESUME_LVL) ? 1'b0
                       : rx_halt_r;
   wire  halt_edge = rx_halt_nxt != rx_halt_r;

   // ---------------- transmit side ----------------
   logic [1:0] cts_sync_r;
   logic       fc_pend_r;
   logic       fc_kind_r;
   logic       fc_step_r;
   logic [7:0] tx_char_r;
   logic       tx_valid_r;

   wire cts_ok = ~enhanced_feature_control_r[ufc_pkg::EF_AUTO_CTS]
                 | ~cts_sync_r[1]; // see R9 R21
   wire load   = ~tx_valid_r | tx_ready_i;
   wire send_fc = load & fc_pend_r & cts_ok;
   // data waits while cts is inactive or the far end sent a pause char
   assign tx_pop = load & ~fc_pend_r & cts_ok & ~remote_pause_r
                   & tx_avail; // see R21
   wire [7:0] fc_char = fc_kind_r
                        ? (fc_step_r ? pause_char_second_r
                                     : pause_char_first_r)
                        : (fc_step_r ? resume_char_second_r
                                     : resume_char_first_r); // see R14
   wire fc_more = send_fc & ~fc_step_r // see R17
                  & (sw_tx == ufc_pkg::SW_BOTH);

   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         cts_sync_r <= 2'h3;
         rx_halt_r  <= 1'b0;
         fc_pend_r  <= 1'b0;
         fc_kind_r  <= 1'b0;
         fc_step_r  <= 1'b0;
         tx_char_r  <= 8'h00;
         tx_valid_r <= 1'b0;
      end
      else
      begin
         cts_sync_r <= {cts_sync_r[0], cts_n_i};
         rx_halt_r  <= rx_halt_nxt;
         if (halt_edge && sw_tx != ufc_pkg::SW_NONE) // see R14 R18
         begin
            fc_pend_r <= 1'b1;
            fc_kind_r <= rx_halt_nxt;
            fc_step_r <= (sw_tx == ufc_pkg::SW_PAIR2);
         end
         else if (fc_more)
            fc_step_r <= 1'b1;
         else if (send_fc)
            fc_pend_r <= 1'b0;
         if (send_fc)
         begin
            tx_char_r  <= fc_char;
            tx_valid_r <= 1'b1;
         end
         else if (tx_pop)
         begin
            tx_char_r  <= tx_head;
            tx_valid_r <= 1'b1;
         end
         else if (load)
            tx_valid_r <= 1'b0;
      end
   end

   // ---------------- status and read path ----------------
   wire rx_int = rx_avail & (rx_level >= rx_trig); // see R20
   wire tx_int = fifo_en ? ((cap - tx_level) > tx_trig)
                         : (tx_level == 7'h00); // see R19
   wire src_rx = interrupt_enable_r[ufc_pkg::IE_RX_READY] & rx_int;
   wire src_tx = interrupt_enable_r[ufc_pkg::IE_TX_READY] & tx_int;
   wire src_sw = interrupt_enable_r[ufc_pkg::IE_SW_FLOW]
                 & (sw_flag_r | special_r); // see R11 R12
   wire [4:0] id_code = src_rx ? ufc_pkg::ID_RX_DATA
                        : src_tx ? ufc_pkg::ID_TX_RDY
                        : src_sw ? ufc_pkg::ID_SW_FLOW
                        : ufc_pkg::ID_NONE;
   wire [7:0] ident = {fifo_en, fifo_en, id_code,
                       ~(src_rx | src_tx | src_sw)};
   wire rts_n_nxt = enhanced_feature_control_r[ufc_pkg::EF_AUTO_RTS]
                    ? rx_halt_r
                    : ~modem_control_r[ufc_pkg::MC_RTS]; // see R10 R21
   wire sleep_nxt = enh_on
                    & interrupt_enable_r[ufc_pkg::IE_SLEEP]; // see R13
   logic [7:0] rdata_nxt;

   always_comb
   begin
      if (!reg_rd_i)
         rdata_nxt = 8'h00;
      else if (reg_addr_i == ufc_pkg::OFS_LINE_CTL)
         rdata_nxt = line_control_r;
      else if (bank_enh && reg_addr_i == ufc_pkg::OFS_ENH_FEAT)
         rdata_nxt = enhanced_feature_control_r;
      else if (bank_enh && reg_addr_i == ufc_pkg::OFS_RESUME1)
         rdata_nxt = resume_char_first_r;
      else if (bank_enh && reg_addr_i == ufc_pkg::OFS_RESUME2)
         rdata_nxt = resume_char_second_r;
      else if (bank_enh && reg_addr_i == ufc_pkg::OFS_PAUSE1)
         rdata_nxt = pause_char_first_r;
      else if (bank_enh && reg_addr_i == ufc_pkg::OFS_PAUSE2)
         rdata_nxt = pause_char_second_r;
      else if (!bank_norm)
         rdata_nxt = 8'h00;
      else if (reg_addr_i == ufc_pkg::OFS_DATA)
         rdata_nxt = rx_avail ? rx_head : 8'h00;
      else if (reg_addr_i == ufc_pkg::OFS_INT_EN)
         rdata_nxt = interrupt_enable_r;
      else if (reg_addr_i == ufc_pkg::OFS_FIFO_CTL)
         rdata_nxt = ident;
      else if (reg_addr_i == ufc_pkg::OFS_MODEM_CTL)
         rdata_nxt = modem_control_r;
      else
         rdata_nxt = 8'h00;
   end

   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         reg_rdata_o    <= 8'h00;
         rts_n_o        <= 1'b1;
         rx_ready_int_o <= 1'b0;
         tx_ready_int_o <= 1'b0;
         sleep_en_o     <= 1'b0;
      end
      else
      begin
         if (reg_rd_i)
            reg_rdata_o <= rdata_nxt;
         rts_n_o        <= rts_n_nxt;
         rx_ready_int_o <= rx_int;
         tx_ready_int_o <= tx_int;
         sleep_en_o     <= sleep_nxt;
      end
   end

   assign tx_char_o  = tx_char_r;
   assign tx_valid_o = tx_valid_r;
endmodule
`default_nettype wire

// ==== ufc_top_assertions.sv ====
// concurrent checks on the ports of the fifo and flow-control block
`timescale 1ns/100ps
`default_nettype none
module ufc_top_assertions (
   input wire logic       clk_i,
   input wire logic       nrst_i,
   input wire logic [2:0] reg_addr_i,
   input wire logic       reg_wr_i,
   input wire logic       reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic [7:0] rx_char_i,
   input wire logic       rx_valid_i,
   input wire logic [7:0] tx_char_o,
   input wire logic       tx_valid_o,
   input wire logic       tx_ready_i,
   input wire logic       cts_n_i,
   input wire logic       rts_n_o,
   input wire logic       rx_ready_int_o,
   input wire logic       tx_ready_int_o,
   input wire logic       sleep_en_o
);
   logic [7:0] lc_r;
   logic [7:0] efr_r;
   // shadows of the bank select and enhanced bits the checks depend on
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         lc_r <= 8'h00;
         efr_r <= 8'h00;
      end
      else if (reg_wr_i && reg_addr_i == 3'h3)
         lc_r <= reg_wdata_i;
      else if (reg_wr_i && reg_addr_i == 3'h2 && lc_r == 8'hbf)
         efr_r <= reg_wdata_i;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   chk_reset_values: assert property (disable iff (1'b0) !nrst_i |=>
      rts_n_o && !tx_valid_o && !tx_ready_int_o && !sleep_en_o
      && reg_rdata_o == 8'h00) else $error("outputs not at reset values");
   chk_bank_readback: assert property (reg_rd_i && reg_addr_i == 3'h3
      |=> reg_rdata_o == $past(lc_r)) else $error("line_control readback");
   chk_locked_zero: assert property (reg_rd_i && lc_r[7]
      && lc_r != 8'hbf && reg_addr_i != 3'h3 |=> reg_rdata_o == 8'h00)
      else $error("locked bank read not zero");
   chk_rdata_hold: assert property (!reg_rd_i
      |=> $stable(reg_rdata_o))
      else $error("read data moved without a read");
   chk_tx_char_hold: assert property (tx_valid_o && !tx_ready_i
      |=> tx_valid_o && $stable(tx_char_o)) else $error("offer withdrawn");
   chk_cts_pause: assert property ((efr_r[7] && cts_n_i)[*4]
      |-> !$rose(tx_valid_o)) else $error("char offered while cts off");
   chk_sleep_gate: assert property (!efr_r[4] |=> !sleep_en_o)
      else $error("sleep allowed without enhanced bit");
   chk_tx_int_start: assert property ($rose(nrst_i)
      |-> ##[1:2] tx_ready_int_o) else $error("tx ready missing");
endmodule
bind ufc_top ufc_top_assertions CHKR (.clk_i(clk_i), .nrst_i(nrst_i),
   .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
   .rx_char_i(rx_char_i), .rx_valid_i(rx_valid_i), .tx_char_o(tx_char_o),
   .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .cts_n_i(cts_n_i),
   .rts_n_o(rts_n_o), .rx_ready_int_o(rx_ready_int_o),
   .tx_ready_int_o(tx_ready_int_o), .sleep_en_o(sleep_en_o));
`default_nettype wire

// ==== ufc_link_model.sv ====
// far side: transmit shift logic that stalls, receive character feed
`timescale 1ns/100ps
`default_nettype none
module ufc_link_model (
   input  wire logic [7:0] tx_char_i,
   input  wire logic       clk_i,
   input  wire logic       tx_valid_i,
   output logic            tx_ready_o,
   output logic [7:0]      rx_char_o,
   output logic            rx_valid_o
);
   logic [7:0] got_q[$];
   initial
   begin
      tx_ready_o = 1'b0;
      rx_char_o = 8'h5a;
      rx_valid_o = 1'b0;
   end
   // random stalls make the block hold its offer
   always @(negedge clk_i)
      tx_ready_o <= ($urandom % 4) != 0;
   always @(posedge clk_i)
      if (tx_valid_i && tx_ready_o)
         got_q.push_back(tx_char_i);
   // after the pulse the data lines show the inverse, not the old char
   task automatic send(input logic [7:0] c);
      @(negedge clk_i);
      rx_char_o <= c;
      rx_valid_o <= 1'b1;
      @(negedge clk_i);
      rx_valid_o <= 1'b0;
      rx_char_o <= ~c;
   endtask
endmodule
`default_nettype wire

// ==== ufc_top_tb.sv ====
// self-checking bench for the fifo and flow-control block
`timescale 1ns/100ps
`default_nettype none
`define CK(n, e, a) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
   $display("unexpected %s exp %h got %h", n, e, a); end end
module ufc_top_tb;
   logic       clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, cts_n = 1'b0;
   logic [2:0] adr = 3'h0;
   logic [7:0] wd = 8'h00, rdat, txc, rxc, d;
   logic       txv, txr, rxv, rts_n, rxi, txi, slp;
   logic [7:0] sent[$];
   int         miscompares = 0, n_checks = 0, cyc = 0;
   always #20 clk = ~clk;
   ufc_top DUT (.clk_i(clk), .nrst_i(nrst), .reg_addr_i(adr), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdat), .rx_char_i(rxc),
      .rx_valid_i(rxv), .tx_char_o(txc), .tx_valid_o(txv), .tx_ready_i(txr),
      .cts_n_i(cts_n), .rts_n_o(rts_n), .rx_ready_int_o(rxi),
      .tx_ready_int_o(txi), .sleep_en_o(slp));
   ufc_link_model LINK (.clk_i(clk), .tx_char_i(txc), .tx_valid_i(txv),
      .tx_ready_o(txr), .rx_char_o(rxc), .rx_valid_o(rxv));
   task automatic wreg(input logic [2:0] a, input logic [7:0] v);
      @(negedge clk);
      adr = a;
      wd = v;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask
   task automatic rreg(input logic [2:0] a);
      @(negedge clk);
      adr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      d = rdat;
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask
   function automatic int rx_trig(input int k);
      return k == 0 ? 8 : k == 1 ? 16 : k == 2 ? 56 : 60;
   endfunction
   task automatic tally_and_finish();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         miscompares++;
         tally_and_finish();
      end
   end
   initial
   begin
      void'($urandom(32'hd72e));
      idle(16);
      nrst = 1'b1;
      rreg(3'h3);
      `CK("line_control", 8'h00, d)
      rreg(3'h2);
      `CK("id fifo bits", 2'b00, d[7:6])
      LINK.send(8'h41);
      idle(3);
      `CK("rx int plain", 1'b1, rxi)
      wreg(3'h3, 8'hbf);
      wreg(3'h2, 8'h10);
      wreg(3'h3, 8'h80);
      rreg(3'h2);
      `CK("locked bank", 8'h00, d)
      wreg(3'h3, 8'h00);
      wreg(3'h1, 8'h30);
      idle(2);
      `CK("sleep enabled", 1'b1, slp)
      for (int k = 0; k < 4; k++)
      begin
         wreg(3'h2, {k[1:0], 6'h07});
         idle(2);
         `CK("rx int flushed", 1'b0, rxi)
         repeat (rx_trig(k) - 1) LINK.send(8'($urandom));
         idle(3);
         `CK("rx int below", 1'b0, rxi)
         LINK.send(8'($urandom));
         idle(3);
         `CK("rx int at trigger", 1'b1, rxi)
      end
      rreg(3'h2);
      `CK("id fifo bits", 2'b11, d[7:6])
      wreg(3'h4, 8'h02);
      idle(2);
      `CK("rts manual", 1'b0, rts_n)
      wreg(3'h3, 8'hbf);
      wreg(3'h2, 8'hd0);
      wreg(3'h3, 8'h00);
      cts_n = 1'b1;
      idle(3);
      `CK("tx int empty", 1'b1, txi)
      `CK("rts halted", 1'b1, rts_n)
      for (int i = 0; i < 60; i++)
      begin
         sent.push_back(8'($urandom));
         wreg(3'h0, sent[i]);
      end
      idle(4);
      `CK("tx held by cts", 1'b0, txv)
      `CK("tx int few spaces", 1'b0, txi)
      cts_n = 1'b0;
      for (int w = 0; w < 2000 && LINK.got_q.size() < 60; w++) idle(1);
      idle(4);
      `CK("tx count", 60, LINK.got_q.size())
      foreach (sent[i]) `CK("tx char", sent[i], LINK.got_q[i])
      `CK("tx int drained", 1'b1, txi)
      repeat (28) rreg(3'h0);
      idle(2);
      `CK("rts resumed", 1'b0, rts_n)
      wreg(3'h3, 8'hbf);
      wreg(3'h6, 8'h13);
      wreg(3'h2, 8'hda);
      wreg(3'h3, 8'h00);
      LINK.send(8'h13);
      rreg(3'h2);
      `CK("id pause", 8'hd0, d)
      repeat (28) LINK.send(8'h55);
      idle(20);
      `CK("pause sent", 8'h13, LINK.got_q[60])
      tally_and_finish();
   end
endmodule
`default_nettype wire
